// >>> hw/bprm_params.svh
// Constants for the bidirectional port block: register offsets, field widths, resets.
// Assumes inclusion by the package and the design files by bare name.
`ifndef BPRM_PARAMS_SVH
`define BPRM_PARAMS_SVH
`define BPRM_W             8
// Port registers keep their word index; the bus byte address is four times it.
`define BPRM_IDX_SHIFT     2
`define BPRM_IDX_PORT_A    32'h0000_0005
`define BPRM_IDX_PORT_B    32'h0000_0006
`define BPRM_OFF_PORT_A    (`BPRM_IDX_PORT_A << `BPRM_IDX_SHIFT)
`define BPRM_OFF_PORT_B    (`BPRM_IDX_PORT_B << `BPRM_IDX_SHIFT)
`define BPRM_OFF_DIR_A     32'h0000_0020
`define BPRM_OFF_DIR_B     32'h0000_0024
`define BPRM_OFF_BITOP     32'h0000_0028
`define BPRM_DIR_RST       8'hFF
`define BPRM_LATCH_RST     8'h00
`define BPRM_BITOP_SET     3
`define BPRM_BITOP_CLR     4
`define BPRM_BITOP_PORT    5
`define BPRM_BITOP_SEL_HI  2
`define BPRM_ZERO32        32'h0000_0000
`define BPRM_SYNC_RST      3'h0
`endif

// >>> hw/bprm_pkg.sv
// Types shared by the bidirectional port block.
// Assumes bprm_params.svh is on the include path.
package bprm_pkg;
    `include "bprm_params.svh"
    typedef enum logic [1:0] {
        BPRM_IDLE = 2'b00,
        BPRM_DATA = 2'b01
    } bprm_state_t;
    typedef logic [`BPRM_W-1:0] bprm_byte_t;
endpackage

// >>> hw/bprm_pin_sync.sv
// Three-stage pin synchroniser with agreement filter for one port.
// Assumes pins are asynchronous to clk_in.
`timescale 1ns/100ps
`include "bprm_params.svh"
module bprm_pin_sync
    import bprm_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             arst_n_in,
    input  wire logic [`BPRM_W-1:0] pin_in,
    output logic      [`BPRM_W-1:0] level_out
);
    genvar g;
    // ****************************************************************
    // Per-bit synchroniser
    // ****************************************************************
    // The first stage feeds only the second; a change is taken once stages two and three agree.
    generate
        for (g = 0; g < `BPRM_W; g = g + 1) begin : g_bit
            logic [2:0] sync_ff;
            logic [2:0] nxt_sync;
            logic       lvl_ff;
            logic       nxt_lvl;
            always_comb begin
                nxt_sync = {sync_ff[1:0], pin_in[g]};
                nxt_lvl  = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : lvl_ff;
            end
            always_ff @(posedge clk_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    sync_ff <= `BPRM_SYNC_RST;
                    lvl_ff  <= 1'b0;
                end else begin
                    sync_ff <= nxt_sync;
                    lvl_ff  <= nxt_lvl;
                end
            end
            assign level_out[g] = lvl_ff;
        end
    endgenerate
endmodule // bprm_pin_sync

// >>> hw/bprm_port.sv
// Two eight-bit bidirectional ports with latches, direction bits and a bit-op helper.
// Assumes an AHB-Lite master with single word transfers and one clock at 125 MHz.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "bprm_params.svh"
// Summary of operation
// - A port data read returns the synchronised pin levels, not the latch.
// - A port data write loads the output latch that drives output pins.
// - A bit-op write acts as read, modify, then whole-register write.
// - A bit set or clear reads all eight pins, changes one bit, writes all eight.
// - A latch loaded while its pin was an input keeps and later drives that value.
// - The latch updates at the end of the access; pins are sampled at its start.
module bprm_port
    import bprm_pkg::*;
(
    input  wire logic               clk_in,
    input  wire logic               arst_n_in,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic [`BPRM_W-1:0] port_a_pin_in,
    input  wire logic [`BPRM_W-1:0] port_b_pin_in,
    output logic      [`BPRM_W-1:0] port_a_pin_out,
    output logic      [`BPRM_W-1:0] port_a_pin_oe_n_out,
    output logic      [`BPRM_W-1:0] port_b_pin_out,
    output logic      [`BPRM_W-1:0] port_b_pin_oe_n_out
);
    bprm_state_t state_ff;
    bprm_state_t nxt_state;
    logic [31:0] addr_ff;
    logic [31:0] nxt_addr;
    logic        wr_ff;
    logic        nxt_wr;
    bprm_byte_t  lat_a_ff;
    bprm_byte_t  lat_b_ff;
    bprm_byte_t  dir_a_ff;
    bprm_byte_t  dir_b_ff;
    bprm_byte_t  nxt_lat_a;
    bprm_byte_t  nxt_lat_b;
    bprm_byte_t  nxt_dir_a;
    bprm_byte_t  nxt_dir_b;
    bprm_byte_t  samp_a_ff;
    bprm_byte_t  samp_b_ff;
    bprm_byte_t  lvl_a;
    bprm_byte_t  lvl_b;
    bprm_byte_t  lvl_a_mux;
    bprm_byte_t  lvl_b_mux;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    bprm_byte_t  rmw_val;
    bprm_byte_t  bit_mask;
    logic        take;

    bprm_pin_sync u_sync_a (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .pin_in    (port_a_pin_in),
        .level_out (lvl_a)
    );
    bprm_pin_sync u_sync_b (
        .clk_in    (clk_in),
        .arst_n_in (arst_n_in),
        .pin_in    (port_b_pin_in),
        .level_out (lvl_b)
    );

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    // Zero wait states; every transfer answers OKAY, unmapped reads give zero.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_ff;
    assign take      = hsel && hready && htrans[1];
    assign lvl_a_mux = lvl_a;
    assign lvl_b_mux = lvl_b;
    assign bit_mask  = bprm_byte_t'(8'h01 << hwdata[`BPRM_BITOP_SEL_HI:0]);

    always_comb begin
        nxt_state = take ? BPRM_DATA : BPRM_IDLE;
        nxt_addr  = take ? haddr : addr_ff;
        nxt_wr    = take && hwrite;
        nxt_rdata = rdata_ff;
        nxt_lat_a = lat_a_ff;
        nxt_lat_b = lat_b_ff;
        nxt_dir_a = dir_a_ff;
        nxt_dir_b = dir_b_ff;
        rmw_val   = `BPRM_LATCH_RST;
        if (take && !hwrite) begin
            unique case (haddr)
                `BPRM_OFF_PORT_A: nxt_rdata = {24'h000000, lvl_a_mux};
                `BPRM_OFF_PORT_B: nxt_rdata = {24'h000000, lvl_b_mux};
                `BPRM_OFF_DIR_A:  nxt_rdata = {24'h000000, dir_a_ff};
                `BPRM_OFF_DIR_B:  nxt_rdata = {24'h000000, dir_b_ff};
                default:          nxt_rdata = `BPRM_ZERO32;
            endcase
        end
        if (state_ff == BPRM_DATA && wr_ff) begin
            unique case (addr_ff)
                `BPRM_OFF_PORT_A: nxt_lat_a = hwdata[`BPRM_W-1:0];
                `BPRM_OFF_PORT_B: nxt_lat_b = hwdata[`BPRM_W-1:0];
                `BPRM_OFF_DIR_A:  nxt_dir_a = hwdata[`BPRM_W-1:0];
                `BPRM_OFF_DIR_B:  nxt_dir_b = hwdata[`BPRM_W-1:0];
                `BPRM_OFF_BITOP: begin
                    rmw_val = hwdata[`BPRM_BITOP_PORT] ? samp_b_ff : samp_a_ff;
                    if (hwdata[`BPRM_BITOP_SET]) begin
                        rmw_val = rmw_val | bit_mask;
                    end else if (hwdata[`BPRM_BITOP_CLR]) begin
                        rmw_val = rmw_val & ~bit_mask;
                    end
                    if (hwdata[`BPRM_BITOP_PORT]) begin
                        nxt_lat_b = rmw_val;
                    end else begin
                        nxt_lat_a = rmw_val;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Pin levels are registered every cycle, so the bit operation in the data phase uses start-of-access pins.
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_ff  <= BPRM_IDLE;
            addr_ff   <= `BPRM_ZERO32;
            wr_ff     <= 1'b0;
            rdata_ff  <= `BPRM_ZERO32;
            lat_a_ff  <= `BPRM_LATCH_RST;
            lat_b_ff  <= `BPRM_LATCH_RST;
            dir_a_ff  <= `BPRM_DIR_RST;
            dir_b_ff  <= `BPRM_DIR_RST;
            samp_a_ff <= `BPRM_LATCH_RST;
            samp_b_ff <= `BPRM_LATCH_RST;
        end else begin
            state_ff  <= nxt_state;
            addr_ff   <= nxt_addr;
            wr_ff     <= nxt_wr;
            rdata_ff  <= nxt_rdata;
            lat_a_ff  <= nxt_lat_a;
            lat_b_ff  <= nxt_lat_b;
            dir_a_ff  <= nxt_dir_a;
            dir_b_ff  <= nxt_dir_b;
            samp_a_ff <= lvl_a;
            samp_b_ff <= lvl_b;
        end
    end

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    // direction gates driver
    assign port_a_pin_out      = lat_a_ff;
    assign port_b_pin_out      = lat_b_ff;
    assign port_a_pin_oe_n_out = dir_a_ff;
    assign port_b_pin_oe_n_out = dir_b_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_READ_PINS: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        take && !hwrite && haddr == `BPRM_OFF_PORT_A |=> hrdata == {24'h000000, $past(lvl_a)})
        else $error("Port A read did not return pin levels.");
    AST_READ_PINS_B: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        take && !hwrite && haddr == `BPRM_OFF_PORT_B |=> hrdata == {24'h000000, $past(lvl_b)})
        else $error("Port B read did not return pin levels.");
    AST_WRITE_LATCH: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        state_ff == BPRM_DATA && wr_ff && addr_ff == `BPRM_OFF_PORT_B
        |=> lat_b_ff == $past(hwdata[`BPRM_W-1:0]))
        else $error("Port B write did not load the latch.");
    AST_RMW_WHOLE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        state_ff == BPRM_DATA && wr_ff && addr_ff == `BPRM_OFF_BITOP
        && !hwdata[`BPRM_BITOP_PORT] && !hwdata[`BPRM_BITOP_SET] && !hwdata[`BPRM_BITOP_CLR]
        |=> lat_a_ff == $past(samp_a_ff))
        else $error("Bit operation did not write back the whole sampled byte.");
    AST_BIT_SET: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        state_ff == BPRM_DATA && wr_ff && addr_ff == `BPRM_OFF_BITOP
        && hwdata[`BPRM_BITOP_PORT] && hwdata[`BPRM_BITOP_SET]
        |=> lat_b_ff == ($past(samp_b_ff) | (8'h01 << $past(hwdata[`BPRM_BITOP_SEL_HI:0]))))
        else $error("Bit set did not merge pin levels with the chosen bit.");
    AST_BIT_CLR: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        state_ff == BPRM_DATA && wr_ff && addr_ff == `BPRM_OFF_BITOP
        && !hwdata[`BPRM_BITOP_PORT] && !hwdata[`BPRM_BITOP_SET] && hwdata[`BPRM_BITOP_CLR]
        |=> lat_a_ff == ($past(samp_a_ff) & ~(8'h01 << $past(hwdata[`BPRM_BITOP_SEL_HI:0]))))
        else $error("Bit clear did not merge pin levels with the chosen bit.");
    AST_HOLD_LATCH: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        !(state_ff == BPRM_DATA && wr_ff) |=> $stable(lat_a_ff) && $stable(lat_b_ff))
        else $error("Latch changed without a write.");
    AST_WRITE_END: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        take && hwrite && !(state_ff == BPRM_DATA && wr_ff)
        |=> $stable(lat_a_ff) && $stable(lat_b_ff))
        else $error("Latch changed during the address phase.");
    AST_DIR_DRIVE: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        state_ff == BPRM_DATA && wr_ff && addr_ff == `BPRM_OFF_DIR_B
        |=> port_b_pin_oe_n_out == $past(hwdata[`BPRM_W-1:0]))
        else $error("Port B driver enable does not follow the direction write.");
    AST_DIR_DRIVE_A: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        state_ff == BPRM_DATA && wr_ff && addr_ff == `BPRM_OFF_DIR_A
        |=> port_a_pin_oe_n_out == $past(hwdata[`BPRM_W-1:0]))
        else $error("Port A driver enable does not follow the direction write.");
    AST_OKAY: assert property (@(posedge clk_in) disable iff (!arst_n_in)
        take |=> hreadyout && !hresp)
        else $error("Bus answer was not a zero-wait OKAY.");
endmodule // bprm_port

// >>> verif/bprm_ext_model.sv
// Model of the circuitry wired to one eight-bit port.
// Assumes the bench gives the level that the outside world puts on each input pin.
`timescale 1ns/100ps
module bprm_ext_model
    import bprm_pkg::*;
(
    input  wire bprm_byte_t ext_in,
    input  wire bprm_byte_t drv_in,
    input  wire bprm_byte_t oe_n_in,
    output bprm_byte_t      pin_out
);
    // ************************************************************
    // Pin resolution
    // ************************************************************
    // The outside world drives a pin only while the port leaves it as an input.
    // That keeps the two drivers from fighting on the wire.
    // direction picks driver.
    assign pin_out = (oe_n_in & ext_in) | (~oe_n_in & drv_in);
endmodule // bprm_ext_model

// >>> verif/bidirectional_port_rmw_tb_top.sv
// Self-checking bench for the two-port block, with AHB-Lite register access.
// Assumes the register map and bit-op word of the design's constants.
`timescale 1ns/100ps
`include "bprm_params.svh"
module bidirectional_port_rmw_tb_top;
    import bprm_pkg::*;
    logic        clk_in = 0, arst_n_in = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]  htrans = 0;
    bprm_byte_t  a_in, b_in, a_out, b_out, a_oe, b_oe, ext_a = 0, ext_b = 0, m, l, e;
    int          n_errors = 0, checks_done = 0, seed = 19, i;
    logic [5:0]  ops [5] = '{6'h2D, 6'h37, 6'h31, 6'h3E, 6'h20};

    initial forever #4 clk_in = ~clk_in;

    bprm_port uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_a_pin_in(a_in),
        .port_b_pin_in(b_in), .port_a_pin_out(a_out), .port_a_pin_oe_n_out(a_oe),
        .port_b_pin_out(b_out), .port_b_pin_oe_n_out(b_oe));
    bprm_ext_model ext_a_m (.ext_in(ext_a), .drv_in(a_out), .oe_n_in(a_oe), .pin_out(a_in));
    bprm_ext_model ext_b_m (.ext_in(ext_b), .drv_in(b_out), .oe_n_in(b_oe), .pin_out(b_in));

    // ************************************************************
    // Checking and bus tasks
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Waits for hready under a bound so a stuck slave cannot hang the run.
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            n_errors++;
            stop_test();
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    function automatic bprm_byte_t exp_bop(input bprm_byte_t p, input logic [5:0] w);
        if (w[`BPRM_BITOP_SET]) begin
            p[w[`BPRM_BITOP_SEL_HI:0]] = 1'b1;
        end else if (w[`BPRM_BITOP_CLR]) begin
            p[w[`BPRM_BITOP_SEL_HI:0]] = 1'b0;
        end
        return p;
    endfunction

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (6) @(posedge clk_in);
        arst_n_in <= 1'b1;
        bus(0, `BPRM_OFF_DIR_A, 0);
        check("dir_a", rd, 32'h0000_00FF);
        check("a_oe", a_oe, 8'hFF);
        check("hresp", hresp, 1'b0);
        ext_a <= 8'($random(seed));
        repeat (6) @(posedge clk_in);
        bus(0, `BPRM_OFF_PORT_A, 0);
        check("pa_read", rd, {24'h0, ext_a});
        check("a_latch", a_out, 8'h00);
        for (i = 0; i < 10; i++) begin
            m = (i == 0) ? 8'h00 : 8'($random(seed));
            l = 8'($random(seed));
            e = 8'($random(seed));
            bus(1, `BPRM_OFF_DIR_A, {24'h0, m});
            bus(1, `BPRM_OFF_PORT_A, {24'hFFFFFF, l});
            @(posedge clk_in);
            check("a_out", a_out, l);
            check("a_oe", a_oe, m);
            ext_a <= e;
            bus(1, 32'h0000_0040, 32'h0000_00FF);
            bus(0, 32'h0000_0040, 0);
            check("unmapped", rd, 0);
            repeat (6) @(posedge clk_in);
            bus(0, `BPRM_OFF_PORT_A, 0);
            check("pa_read", rd, {24'h0, (m & e) | (~m & l)});
        end
        l = exp_bop((m & e) | (~m & l), 6'h12);
        bus(1, `BPRM_OFF_BITOP, 32'h0000_0012);
        @(posedge clk_in);
        check("a_bitop", a_out, l);
        repeat (6) @(posedge clk_in);
        l = (m & e) | (~m & l);
        bus(1, `BPRM_OFF_BITOP, 0);
        @(posedge clk_in);
        check("a_rmw", a_out, l);
        // Upper half of port B is input, so bit ops latch whatever the pins show.
        e = 8'($random(seed));
        ext_b <= e;
        bus(1, `BPRM_OFF_DIR_B, 32'h0000_00F0);
        bus(1, `BPRM_OFF_PORT_B, 32'h0000_000A);
        l = 8'h0A;
        repeat (6) @(posedge clk_in);
        for (i = 0; i < 5; i++) begin
            l = exp_bop((e & 8'hF0) | (l & 8'h0F), ops[i]);
            bus(1, `BPRM_OFF_BITOP, {26'h0, ops[i]});
            @(posedge clk_in);
            check("b_bitop", b_out, l);
            repeat (6) @(posedge clk_in);
        end
        ext_b <= ~e;
        bus(1, `BPRM_OFF_DIR_B, 0);
        @(posedge clk_in);
        check("b_turned", b_out, l);
        check("b_oe", b_oe, 8'h00);
        check("b_pin", b_in, l);
        repeat (6) @(posedge clk_in);
        bus(0, `BPRM_OFF_PORT_B, 0);
        check("pb_read", rd, {24'h0, l});
        stop_test();
    end
endmodule // bidirectional_port_rmw_tb_top
